// [src/eip_pkg.sv]
package eip_pkg;

  // Widths of the register port and of the condition vectors.
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SRC_W = 9;

  // Bit positions of the interruptible conditions.
  localparam int unsigned BIT_PHY = 8;
  localparam int unsigned BIT_XCVR = 7;
  localparam int unsigned BIT_LOCK = 6;
  localparam int unsigned BIT_TX = 5;
  localparam int unsigned BIT_OVR = 4;
  localparam int unsigned BIT_REJ = 3;
  localparam int unsigned BIT_RX = 2;
  localparam int unsigned BIT_NEG = 1;
  localparam int unsigned BIT_ACC = 0;
  localparam int unsigned NUM_EVT = 6;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFF_PENDING = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_EVT_STATUS = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_EVT_MASK = 8'h24;

  // Reset values.
  localparam logic [SRC_W-1:0] PEND_RST = 9'h000;
  localparam logic [SRC_W-1:0] SRC_RST = 9'h040;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  // Block events, sticky in the event status register.
  localparam int unsigned EVT_W = 3;
  localparam int unsigned EVT_PHY = 0;
  localparam int unsigned EVT_XCVR = 1;
  localparam int unsigned EVT_PEND = 2;
  localparam logic [EVT_W-1:0] EVT_RST = 3'h0;

  // PHY access wait after the PHY reset pin is released.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned PHY_WAIT_NS = 5000000;
  localparam int unsigned PHY_WAIT_CYC =
    (PHY_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    TMR_HOLD = 3'b001,
    TMR_COUNT = 3'b010,
    TMR_DONE = 3'b100
  } eip_tmr_st_t;

endpackage

// [src/eip_tmr_if.sv]
`timescale 1ns/100ps
interface eip_tmr_if;
  logic armed;
  logic done;
  modport ctl (output armed, input done);
  modport tmr (input armed, output done);
endinterface

// [src/eip_sync.sv]
`timescale 1ns/100ps
module eip_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_b,
  // Asynchronous levels in, synchronised levels out.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } eip_sync_st_t;

  eip_sync_st_t st_q;
  eip_sync_st_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;

endmodule

// [src/eip_phy_timer.sv]
`timescale 1ns/100ps
module eip_phy_timer #(
  parameter int unsigned CYC = eip_pkg::PHY_WAIT_CYC
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_b,
  // Arm level in, done level out.
  eip_tmr_if.tmr tif
);

  localparam int unsigned CNT_W = $clog2(CYC + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYC - 1);

  typedef struct packed {
    eip_pkg::eip_tmr_st_t st;
    logic [CNT_W-1:0] cnt;
  } eip_tmr_state_t;

  eip_tmr_state_t s_q;
  eip_tmr_state_t s_d;

  // The count restarts whenever the PHY is put back into reset.
  always_comb begin
    s_d = s_q;
    case (s_q.st)
      eip_pkg::TMR_HOLD: begin
        s_d.cnt = '0;
        if (tif.armed) begin
          s_d.st = eip_pkg::TMR_COUNT;
        end
      end
      eip_pkg::TMR_COUNT: begin
        if (!tif.armed) begin
          s_d.st = eip_pkg::TMR_HOLD;
          s_d.cnt = '0;
        end else if (s_q.cnt == LAST) begin
          s_d.st = eip_pkg::TMR_DONE;
        end else begin
          s_d.cnt = s_q.cnt + CNT_W'(1);
        end
      end
      eip_pkg::TMR_DONE: begin
        if (!tif.armed) begin
          s_d.st = eip_pkg::TMR_HOLD;
          s_d.cnt = '0;
        end
      end
      default: begin
        s_d.st = eip_pkg::TMR_HOLD;
        s_d.cnt = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '{st: eip_pkg::TMR_HOLD, cnt: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign tif.done = (s_q.st == eip_pkg::TMR_DONE);

endmodule

// [src/eip_pending.sv]
// What this block does
// - Each pending bit is the latched status bit ANDed with its enable bit.
// - The interrupt output is high while any pending bit is set, else low.
// - The pending register is read only and host writes leave it unchanged.
// - Bits 31 to 9 of the pending register read as zero and reset to zero.
// - PHY reset done (bit 8) sets only 5 ms after the PHY reset pin rises.
// - Bit 7 sets once transceiver and MAC are ready, or after reset if none.
// - Receive clock lock (bit 6) is held at one at all times.
// - Bit 5 reports a frame successfully transmitted.
// - Bit 4 reports receive buffer overflow with data lost.
// - Bit 3 reports a rejected incoming frame.
// - Bit 2 reports a packet successfully received.
// - Bit 1 reports completed link auto-negotiation.
// - Bit 0 reports a completed MAC core configuration register access.
// - A set enable bit lets its status bit through; a clear one blocks it.
`timescale 1ns/100ps
module eip_pending #(
  parameter int unsigned PHY_WAIT_CYC = eip_pkg::PHY_WAIT_CYC,
  parameter bit HAS_XCVR = 1'b1
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_b,
  // Register port.
  input wire logic [eip_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [eip_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [eip_pkg::DATA_W-1:0] reg_rdata,
  // Latched status and enable vectors from the neighbouring registers.
  input wire logic [eip_pkg::SRC_W-1:0] latched_status_vector,
  input wire logic [eip_pkg::SRC_W-1:0] enable_vector,
  // Pins.
  input wire logic phy_reset_pin_n,
  input wire logic transceiver_ready_pin,
  // Core condition inputs on this clock.
  input wire logic mac_out_of_reset,
  input wire logic tx_frame_done,
  input wire logic rx_buffer_overflow,
  input wire logic rx_frame_rejected,
  input wire logic rx_frame_done,
  input wire logic link_negotiation_done,
  input wire logic core_reg_access_done,
  // Condition vector toward the status register.
  output logic [eip_pkg::SRC_W-1:0] source_vector,
  // Pending vector and interrupts.
  output logic [eip_pkg::SRC_W-1:0] pending_vector,
  output logic intr,
  output logic evt_irq
);

  typedef struct packed {
    logic [eip_pkg::SRC_W-1:0] pend;
    logic intr;
    logic [eip_pkg::SRC_W-1:0] src;
    logic [eip_pkg::DATA_W-1:0] rdata;
    logic [eip_pkg::EVT_W-1:0] evt;
    logic [eip_pkg::EVT_W-1:0] mask;
    logic evt_irq;
  } eip_state_t;

  eip_state_t s_q;
  eip_state_t s_d;

  function automatic logic hit(
    input logic [eip_pkg::ADDR_W-1:0] addr,
    input logic [eip_pkg::ADDR_W-1:0] off
  );
    hit = (addr == off);
  endfunction

  // Pin synchronisation: bit 1 is the PHY reset pin, bit 0 transceiver ready.
  logic [1:0] pin_sync;
  logic phy_pin_s;
  logic xcvr_pin_s;

  eip_sync #(
    .W(2)
  ) u_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .d({phy_reset_pin_n, transceiver_ready_pin}),
    .q(pin_sync)
  );

  assign phy_pin_s = pin_sync[1];
  assign xcvr_pin_s = pin_sync[0];

  // PHY access wait timer, armed while the PHY is out of reset.
  eip_tmr_if tmr_bus ();

  assign tmr_bus.armed = phy_pin_s;

  eip_phy_timer #(
    .CYC(PHY_WAIT_CYC)
  ) u_phy_timer (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .tif(tmr_bus.tmr)
  );

  // Single-cycle core conditions, in bit order from bit 0 upward.
  logic [eip_pkg::NUM_EVT-1:0] core_evt;

  assign core_evt[eip_pkg::BIT_ACC] = core_reg_access_done;
  assign core_evt[eip_pkg::BIT_NEG] = link_negotiation_done;
  assign core_evt[eip_pkg::BIT_RX] = rx_frame_done;
  assign core_evt[eip_pkg::BIT_REJ] = rx_frame_rejected;
  assign core_evt[eip_pkg::BIT_OVR] = rx_buffer_overflow;
  assign core_evt[eip_pkg::BIT_TX] = tx_frame_done;

  logic [eip_pkg::EVT_W-1:0] evt_set;
  logic [eip_pkg::EVT_W-1:0] evt_clr;
  logic evt_rd;

  assign evt_rd = reg_rd && hit(reg_addr, eip_pkg::OFF_EVT_STATUS);

  always_comb begin
    s_d = s_q;

    // Condition vector toward the status register.
    s_d.src[eip_pkg::BIT_PHY] = tmr_bus.done;
    if (HAS_XCVR) begin
      s_d.src[eip_pkg::BIT_XCVR] = xcvr_pin_s && mac_out_of_reset;
    end else begin
      s_d.src[eip_pkg::BIT_XCVR] = 1'b1;
    end
    s_d.src[eip_pkg::BIT_LOCK] = 1'b1;
    s_d.src[eip_pkg::NUM_EVT-1:0] = core_evt;

    // Pending path: one register stage, no other latching.
    s_d.pend = latched_status_vector & enable_vector;
    s_d.intr = |s_d.pend;

    // Block events: rising edges of readiness and of the interrupt.
    evt_set = '0;
    evt_set[eip_pkg::EVT_PHY] =
      s_d.src[eip_pkg::BIT_PHY] && !s_q.src[eip_pkg::BIT_PHY];
    evt_set[eip_pkg::EVT_XCVR] =
      s_d.src[eip_pkg::BIT_XCVR] && !s_q.src[eip_pkg::BIT_XCVR];
    evt_set[eip_pkg::EVT_PEND] = s_d.intr && !s_q.intr;
    evt_clr = evt_rd ? s_q.evt : '0;
    // A set arriving with the clearing read is kept.
    s_d.evt = (s_q.evt & ~evt_clr) | evt_set;

    // Register writes; the pending offset has no write path.
    if (reg_wr && hit(reg_addr, eip_pkg::OFF_EVT_MASK)) begin
      s_d.mask = reg_wdata[eip_pkg::EVT_W-1:0];
    end
    s_d.evt_irq = |(s_d.evt & s_d.mask);

    // Read data stands only in the cycle after the read strobe.
    s_d.rdata = eip_pkg::RDATA_RST;
    if (reg_rd) begin
      if (hit(reg_addr, eip_pkg::OFF_PENDING)) begin
        s_d.rdata[eip_pkg::SRC_W-1:0] = s_q.pend;
      end else if (evt_rd) begin
        s_d.rdata[eip_pkg::EVT_W-1:0] = s_q.evt;
      end else if (hit(reg_addr, eip_pkg::OFF_EVT_MASK)) begin
        s_d.rdata[eip_pkg::EVT_W-1:0] = s_q.mask;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '{
        pend: eip_pkg::PEND_RST,
        intr: 1'b0,
        src: eip_pkg::SRC_RST,
        rdata: eip_pkg::RDATA_RST,
        evt: eip_pkg::EVT_RST,
        mask: eip_pkg::EVT_RST,
        evt_irq: 1'b0
      };
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign source_vector = s_q.src;
  assign pending_vector = s_q.pend;
  assign intr = s_q.intr;
  assign evt_irq = s_q.evt_irq;

  // Checking helpers: cycles the synchronised PHY pin has stood high.
  int unsigned phy_hi_cnt;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      phy_hi_cnt <= 0;
    end else if (!phy_pin_s) begin
      phy_hi_cnt <= 0;
    end else if (phy_hi_cnt < PHY_WAIT_CYC + 4) begin
      phy_hi_cnt <= phy_hi_cnt + 1;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking

  default disable iff (!rst_b);

  AST_PEND_AND: assert property (
    1'b1 |=> pending_vector == $past(latched_status_vector & enable_vector)
  ) else $error("pending vector is not status AND enable");

  AST_INTR_ANY: assert property (
    (latched_status_vector & enable_vector) != '0 |=> intr ##0
    (pending_vector != '0)
  ) else $error("interrupt low while a pending bit is set");

  AST_INTR_NONE: assert property (
    (latched_status_vector & enable_vector) == '0 |=> !intr
  ) else $error("interrupt high with no pending bit");

  AST_PEND_RO: assert property (
    reg_wr && reg_addr == eip_pkg::OFF_PENDING
    && $stable(latched_status_vector) && $stable(enable_vector)
    |=> $stable(pending_vector)
  ) else $error("write to pending register changed it");

  AST_RSVD_ZERO: assert property (
    reg_rd && reg_addr == eip_pkg::OFF_PENDING |=>
    reg_rdata[eip_pkg::DATA_W-1:eip_pkg::SRC_W] == '0
    && reg_rdata[eip_pkg::SRC_W-1:0] == $past(pending_vector)
  ) else $error("pending read returned wrong data");

  AST_PHY_WAIT: assert property (
    $rose(source_vector[eip_pkg::BIT_PHY]) |->
    phy_hi_cnt >= PHY_WAIT_CYC
  ) else $error("PHY reset done rose before the wait elapsed");

  AST_PHY_DROP: assert property (
    !phy_pin_s |=> ##1 !source_vector[eip_pkg::BIT_PHY]
  ) else $error("PHY reset done stayed set while PHY in reset");

  AST_XCVR_FOLLOW: assert property (
    HAS_XCVR |=> source_vector[eip_pkg::BIT_XCVR] ==
    $past(xcvr_pin_s && mac_out_of_reset)
  ) else $error("transceiver ready does not follow its sources");

  AST_XCVR_NONE: assert property (
    !HAS_XCVR |=> source_vector[eip_pkg::BIT_XCVR]
  ) else $error("transceiver ready low without a transceiver");

  AST_LOCK_ONE: assert property (
    source_vector[eip_pkg::BIT_LOCK]
  ) else $error("receive clock lock bit is not one");

  for (genvar i = 0; i < eip_pkg::NUM_EVT; i++) begin : g_evt_chk
    AST_EVT: assert property (
      1'b1 |=> source_vector[i] == $past(core_evt[i])
    ) else $error("core condition not reported in its bit");
  end

  AST_EN_BLOCK: assert property (
    1'b1 |=> (pending_vector & ~$past(enable_vector)) == '0
  ) else $error("disabled condition reached the pending vector");

  // A clearing read that meets a new interrupt edge must keep that event.
  AST_EVT_SET_WINS: assert property (
    evt_rd && !intr && (latched_status_vector & enable_vector) != '0
    |=> s_q.evt[eip_pkg::EVT_PEND]
  ) else $error("interrupt event lost on a clearing read");

  AST_EVT_CLR: assert property (
    evt_rd && evt_set == '0 |=> s_q.evt == '0
  ) else $error("event status not cleared by its read");

  AST_EVT_HOLD: assert property (
    !evt_rd |=> (s_q.evt & $past(s_q.evt)) == $past(s_q.evt)
  ) else $error("event status bit dropped without a read");

  AST_PHY_EVT: assert property (
    $rose(source_vector[eip_pkg::BIT_PHY]) |-> s_q.evt[eip_pkg::EVT_PHY]
  ) else $error("PHY reset done rise not recorded as an event");

  AST_XCVR_EVT: assert property (
    $rose(source_vector[eip_pkg::BIT_XCVR]) |-> s_q.evt[eip_pkg::EVT_XCVR]
  ) else $error("transceiver ready rise not recorded as an event");

  // The event interrupt must stand while a masked-in event waits.
  AST_EVT_IRQ: assert property (
    (s_q.evt & s_q.mask) != '0 && !reg_wr && !reg_rd |=> evt_irq
  ) else $error("event interrupt low with an unmasked event");

  AST_MASK_WR: assert property (
    reg_wr && reg_addr == eip_pkg::OFF_EVT_MASK |=>
    s_q.mask == $past(reg_wdata[eip_pkg::EVT_W-1:0])
  ) else $error("event mask write not taken");

  AST_MASK_RD: assert property (
    reg_rd && reg_addr == eip_pkg::OFF_EVT_MASK |=>
    reg_rdata[eip_pkg::EVT_W-1:0] == $past(s_q.mask)
    && reg_rdata[eip_pkg::DATA_W-1:eip_pkg::EVT_W] == '0
  ) else $error("event mask read returned wrong data");

  // Read data stands for one cycle only, so idle cycles must read as zero.
  AST_RDATA_IDLE: assert property (
    !reg_rd |=> reg_rdata == '0
  ) else $error("read data not zero outside a read answer");

  AST_RD_UNMAPPED: assert property (
    reg_rd && reg_addr != eip_pkg::OFF_PENDING
    && reg_addr != eip_pkg::OFF_EVT_STATUS
    && reg_addr != eip_pkg::OFF_EVT_MASK |=> reg_rdata == '0
  ) else $error("unmapped read returned data");

endmodule

// [dv/eip_partner.sv]
`timescale 1ns/100ps
// Stands in for the status register that sits beside the pending logic.
module eip_partner (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_b,
  // Conditions in, software clear in, latched status out.
  input wire logic [eip_pkg::SRC_W-1:0] source_vector,
  input wire logic [eip_pkg::SRC_W-1:0] clr,
  output logic [eip_pkg::SRC_W-1:0] latched_status_vector
);
  logic [eip_pkg::SRC_W-1:0] status_q;
  assign latched_status_vector = status_q;
  // A condition present in the clear cycle survives the clear.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~clr) | source_vector;
    end
  end
endmodule

// [dv/eip_pending_tb.sv]
`timescale 1ns/100ps
module eip_pending_tb;
  localparam int unsigned WAIT = 20;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [8:0] status, enable = 9'h000, clr = 9'h000, src, pend;
  logic phy_n = 1'b0, xcvr = 1'b0, mac = 1'b0;
  logic [5:0] cond = 6'h00;
  logic intr, evt_irq;
  int fails = 0, tests_run = 0, cycles = 0;

  eip_pending #(.PHY_WAIT_CYC(WAIT), .HAS_XCVR(1'b1)) eip_pending_inst (
    .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .latched_status_vector(status),
    .enable_vector(enable), .phy_reset_pin_n(phy_n),
    .transceiver_ready_pin(xcvr), .mac_out_of_reset(mac),
    .tx_frame_done(cond[5]), .rx_buffer_overflow(cond[4]),
    .rx_frame_rejected(cond[3]), .rx_frame_done(cond[2]),
    .link_negotiation_done(cond[1]), .core_reg_access_done(cond[0]),
    .source_vector(src), .pending_vector(pend), .intr(intr),
    .evt_irq(evt_irq));
  eip_partner eip_partner_inst (.core_clk(core_clk), .rst_b(rst_b),
    .source_vector(src), .clr(clr), .latched_status_vector(status));

  always #5 core_clk = ~core_clk;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails = fails + 1;
      stop_test();
    end
  end

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] exp, string what);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk(what, exp, reg_rdata);
  endtask

  task automatic t_reset();
    @(negedge core_clk);
    chk("pending", 32'h0, {23'h0, pend});
    chk("intr", 32'h0, {31'h0, intr});
    chk("lock", 32'h1, {31'h0, src[6]});
    rd(8'h30, 32'h0, "unmapped");
  endtask

  // Each core condition is latched, passed by its enable, then removed.
  task automatic t_and();
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk);
      cond[i] <= 1'b1;
      cyc(1);
      cond[i] <= 1'b0;
      cyc(3);
      @(negedge core_clk);
      chk("blocked", 32'h0, {23'h0, pend});
      @(posedge core_clk);
      enable <= 9'h001 << i;
      cyc(2);
      @(negedge core_clk);
      chk("pending bit", 32'h1 << i, {23'h0, pend});
      chk("intr set", 32'h1, {31'h0, intr});
      @(posedge core_clk);
      if (i % 2 == 0) begin
        enable <= 9'h000;
      end else begin
        clr <= 9'h001 << i;
      end
      cyc(1);
      clr <= 9'h000;
      cyc(2);
      @(negedge core_clk);
      chk("removed", 32'h0, {23'h0, pend});
      chk("intr clear", 32'h0, {31'h0, intr});
      @(posedge core_clk);
      enable <= 9'h000;
    end
    @(posedge core_clk);
    enable <= 9'h040;
    cyc(2);
    @(negedge core_clk);
    chk("lock pending", 32'h40, {23'h0, pend});
    @(posedge core_clk);
    enable <= 9'h000;
    cyc(2);
  endtask

  task automatic t_phy();
    rd(8'h20, 32'h4, "event status");
    @(posedge core_clk);
    phy_n <= 1'b1;
    cyc(WAIT);
    @(negedge core_clk);
    chk("phy early", 32'h0, {31'h0, src[8]});
    cyc(8);
    @(negedge core_clk);
    chk("phy done", 32'h1, {31'h0, src[8]});
    chk("evt masked", 32'h0, {31'h0, evt_irq});
    wr(8'h24, 32'h1);
    cyc(1);
    @(negedge core_clk);
    chk("evt irq", 32'h1, {31'h0, evt_irq});
    rd(8'h20, 32'h1, "phy event");
    cyc(1);
    @(negedge core_clk);
    chk("evt cleared", 32'h0, {31'h0, evt_irq});
    @(posedge core_clk);
    enable <= 9'h100;
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10, 32'h100, "pending ro");
    @(posedge core_clk);
    enable <= 9'h000;
  endtask

  task automatic t_xcvr();
    @(posedge core_clk);
    xcvr <= 1'b1;
    cyc(5);
    @(negedge core_clk);
    chk("xcvr mac off", 32'h0, {31'h0, src[7]});
    @(posedge core_clk);
    mac <= 1'b1;
    cyc(5);
    @(negedge core_clk);
    chk("xcvr ready", 32'h1, {31'h0, src[7]});
  endtask

  // A clearing read in the cycle the interrupt rises keeps that event.
  task automatic t_evt();
    wr(8'h24, 32'h4);
    rd(8'h24, 32'h4, "mask readback");
    chk("evt pend irq", 32'h1, {31'h0, evt_irq});
    @(posedge core_clk);
    enable <= 9'h040;
    reg_rd <= 1'b1;
    reg_addr <= 8'h20;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk("race read", 32'h6, reg_rdata);
    chk("race intr", 32'h1, {31'h0, intr});
    rd(8'h20, 32'h4, "event kept");
    cyc(1);
    @(negedge core_clk);
    chk("evt irq low", 32'h0, {31'h0, evt_irq});
    @(posedge core_clk);
    enable <= 9'h000;
  endtask

  initial begin
    cyc(16);
    rst_b <= 1'b1;
    t_reset();
    t_and();
    t_phy();
    t_xcvr();
    t_evt();
    stop_test();
  end
endmodule
